// file: hdl/ccrs_sequencer.sv
// ccrs_sequencer: master, bit and frame clocks for a stereo codec plus
// its reset release order, steered over a plain register port
// assumes bus strobes on mclk_i; external bit clock pins are asynchronous
`timescale 1ns/1ps
`include "ccrs_map.svh"

module ccrs_sequencer
   import ccrs_pkg::*;
(
   input  wire logic                    mclk_i,
   input  wire logic                    resetn_i,
   input  wire ccrs_bus_t               bus_i,
   output logic [`CCRS_DATA_W-1:0]      rdata_o,
   input  wire logic                    port2_receive_bit_clock_in_i,
   input  wire logic                    transmit_bit_clock_pin_i,
   output logic                         codec_master_clock_o,
   output logic                         port2_transmit_bit_clock_out_o,
   output logic                         port2_transmit_frame_sync_out_o,
   output logic                         host_port_general_output_o
);

   ccrs_st_t st_reg;
   ccrs_st_t st_next;
   logic     ext_pin;
   logic     ext_tick;
   logic     base_tick;
   logic     mclk_out;
   logic     bclk_out;
   logic     bclk_rise;

   function automatic logic [`CCRS_DIV_W-1:0] nz(
      input logic [`CCRS_DIV_W-1:0] v);
      nz = (v == '0) ? `CCRS_DIV_W'(1) : v;
   endfunction

   // mux ahead of the synchroniser; only stage 1 reads stage 0
   assign ext_pin  = st_reg.bsel ? transmit_bit_clock_pin_i
                                 : port2_receive_bit_clock_in_i;
   assign ext_tick = st_reg.xsync[1] & ~st_reg.xsync[2];
   // one base for both ports keeps the clocks integer related
   assign base_tick = st_reg.ext ? ext_tick : 1'b1;

   ccrs_clk_div u_port0_div
   (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .run_i    (st_reg.run0),
      .tick_i   (base_tick),
      .half_i   (st_reg.div0),
      .clk_o    (mclk_out),
      .rise_o   ()
   );

   ccrs_clk_div u_port2_div
   (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .run_i    (st_reg.run2),
      .tick_i   (base_tick),
      .half_i   (st_reg.ext ? `CCRS_EXT_HALF : st_reg.div2),
      .clk_o    (bclk_out),
      .rise_o   (bclk_rise)
   );

   always_comb
   begin
      st_next       = st_reg;
      st_next.rdata = '0;
      st_next.xsync = {st_reg.xsync[1:0], ext_pin};
      if (bus_i.wr)
      begin
         unique case (bus_i.addr)
            `CCRS_OFF_CTRL:
            begin
               st_next.ext  = bus_i.wdata[`CCRS_CTRL_EXT];
               st_next.bsel = bus_i.wdata[`CCRS_CTRL_BSEL];
            end
            `CCRS_OFF_DIV_MCLK: st_next.div0 = bus_i.wdata[`CCRS_DIV_W-1:0];
            `CCRS_OFF_DIV_BCLK: st_next.div2 = bus_i.wdata[`CCRS_DIV_W-1:0];
            `CCRS_OFF_GAP:      st_next.gap  = bus_i.wdata[`CCRS_DIV_W-1:0];
            default: ;
         endcase
      end
      if (bus_i.rd)
      begin
         unique case (bus_i.addr)
            `CCRS_OFF_CTRL:
            begin
               st_next.rdata[`CCRS_CTRL_EXT]  = st_reg.ext;
               st_next.rdata[`CCRS_CTRL_BSEL] = st_reg.bsel;
            end
            `CCRS_OFF_DIV_MCLK: st_next.rdata[`CCRS_DIV_W-1:0] = st_reg.div0;
            `CCRS_OFF_DIV_BCLK: st_next.rdata[`CCRS_DIV_W-1:0] = st_reg.div2;
            `CCRS_OFF_GAP:      st_next.rdata[`CCRS_DIV_W-1:0] = st_reg.gap;
            `CCRS_OFF_STATUS:
            begin
               st_next.rdata[`CCRS_STAT_CODEC] = st_reg.codec_rel;
               st_next.rdata[`CCRS_STAT_FLAG0] = ~st_reg.run0;
               st_next.rdata[`CCRS_STAT_FLAG2] = ~st_reg.run2;
               st_next.rdata[`CCRS_STAT_BUSY]  = st_reg.seq != S_IDLE &&
                                                 st_reg.seq != S_BCLK;
            end
            default: ;
         endcase
      end

      // power-on order, same in both base modes
      unique case (st_reg.seq)
         S_IDLE:
            if (bus_i.wr && bus_i.addr == `CCRS_OFF_CTRL &&
                bus_i.wdata[`CCRS_CTRL_START])
            begin
               st_next.seq       = S_CODEC;
               st_next.codec_rel = 1'b1;
            end
         S_CODEC:
         begin
            st_next.seq  = S_MCLK;
            st_next.run0 = 1'b1;
            st_next.gcnt = nz(st_reg.gap);
         end
         S_MCLK:
            // a zero gap still leaves one clock between releases
            if (st_reg.gcnt <= `CCRS_DIV_W'(1))
            begin
               st_next.seq  = S_BCLK;
               st_next.run2 = 1'b1;
            end
            else
               st_next.gcnt = st_reg.gcnt - `CCRS_DIV_W'(1);
         S_BCLK: ;
      endcase

      // stop wins over start: codec back in reset, ports held
      if (bus_i.wr && bus_i.addr == `CCRS_OFF_CTRL &&
          bus_i.wdata[`CCRS_CTRL_STOP])
      begin
         st_next.seq       = S_IDLE;
         st_next.codec_rel = 1'b0;
         st_next.run0      = 1'b0;
         st_next.run2      = 1'b0;
      end

      // frame clock counts bit clock periods, 64 to a frame
      if (st_reg.run2 && !st_reg.frame && st_reg.fcnt == '0 && !bclk_rise &&
          !st_next.run2)
         st_next.fcnt = '0;
      if (!st_reg.run2)
      begin
         st_next.fcnt  = '0;
         st_next.frame = 1'b0;
      end
      else if (bclk_rise)
      begin
         if (st_reg.fcnt == `CCRS_FRAME_LAST)
         begin
            st_next.fcnt  = '0;
            st_next.frame = ~st_reg.frame;
         end
         else
            st_next.fcnt = st_reg.fcnt + `CCRS_FCNT_W'(1);
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         st_reg      <= '0;
         st_reg.seq  <= S_IDLE;
         st_reg.div0 <= `CCRS_DIV_RST;
         st_reg.div2 <= `CCRS_DIV_RST;
         st_reg.gap  <= `CCRS_GAP_RST;
      end
      else
         st_reg <= st_next;
   end

   assign rdata_o                         = st_reg.rdata;
   assign codec_master_clock_o            = mclk_out;
   assign port2_transmit_bit_clock_out_o  = bclk_out;
   assign port2_transmit_frame_sync_out_o = st_reg.frame;
   assign host_port_general_output_o      = st_reg.codec_rel;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   a_mclk_default: assert property (
      !st_reg.run0 && $past(!st_reg.run0) && $past(resetn_i)
      |-> codec_master_clock_o != $past(codec_master_clock_o))
      else $error("held master port not at half clock");
   a_mclk_restart: assert property (
      $rose(st_reg.run0) |=> !codec_master_clock_o)
      else $error("master port did not restart on release");
   a_ports_locked: assert property (
      st_reg.run2 |-> st_reg.run0)
      else $error("bit port running without master port");
   a_release_gap: assert property (
      $rose(st_reg.run2) |-> $past(st_reg.run0))
      else $error("ports released in the same clock");
   a_codec_first: assert property (
      $rose(st_reg.run0) |-> $past(st_reg.codec_rel))
      else $error("master port released before codec reset");
   a_start_order: assert property (
      st_reg.seq == S_CODEC && !bus_i.wr
      |=> st_reg.run0 && !st_reg.run2 && host_port_general_output_o)
      else $error("release order broken");
   a_codec_held: assert property (
      st_reg.seq == S_IDLE |-> !host_port_general_output_o)
      else $error("codec reset released while idle");
   a_ext_edge: assert property (
      st_reg.ext && st_reg.run2 && $past(st_reg.ext && st_reg.run2, 2) &&
      $changed(port2_transmit_bit_clock_out_o) |-> $past(ext_tick))
      else $error("bit clock moved without external edge");
   a_frame_div: assert property (
      $past(st_reg.run2) && $changed(port2_transmit_frame_sync_out_o)
      |-> $past(bclk_rise) && $past(st_reg.fcnt) == `CCRS_FRAME_LAST)
      else $error("frame clock not derived from bit clock");

   c_seq_done:   cover property ($rose(st_reg.run2));
   c_ext_frame:  cover property (st_reg.ext && $rose(st_reg.frame));
   c_stop:       cover property ($fell(st_reg.run0));
   c_read_stat:  cover property (bus_i.rd &&
                                 bus_i.addr == `CCRS_OFF_STATUS);

endmodule // ccrs_sequencer

// file: hdl/ccrs_map.svh
// ccrs_map.svh: offsets, field positions, reset values and counts of the
// codec clock and reset sequencer; include by bare name, definitions only
`ifndef CCRS_MAP_SVH
`define CCRS_MAP_SVH

`define CCRS_ADDR_W       8
`define CCRS_DATA_W       32
`define CCRS_DIV_W        8
`define CCRS_FCNT_W       5

`define CCRS_OFF_CTRL     8'h00
`define CCRS_OFF_DIV_MCLK 8'h04
`define CCRS_OFF_DIV_BCLK 8'h08
`define CCRS_OFF_GAP      8'h0c
`define CCRS_OFF_STATUS   8'h10

`define CCRS_CTRL_START   0
`define CCRS_CTRL_STOP    1
`define CCRS_CTRL_EXT     2
`define CCRS_CTRL_BSEL    3

`define CCRS_STAT_CODEC   0
`define CCRS_STAT_FLAG0   1
`define CCRS_STAT_FLAG2   2
`define CCRS_STAT_BUSY    3

`define CCRS_DIV_RST      8'h01
`define CCRS_GAP_RST      8'h01
`define CCRS_EXT_HALF     8'h02
`define CCRS_FRAME_LAST   5'h1f

`endif

// file: hdl/ccrs_pkg.sv
// ccrs_pkg: types shared by the sequencer and its divider
// assumes ccrs_map.svh is on the include path
`include "ccrs_map.svh"

package ccrs_pkg;

   typedef enum logic [1:0] {S_IDLE, S_CODEC, S_MCLK, S_BCLK} ccrs_seq_t;

   typedef struct packed {
      logic [`CCRS_ADDR_W-1:0] addr;
      logic [`CCRS_DATA_W-1:0] wdata;
      logic                    wr;
      logic                    rd;
   } ccrs_bus_t;

   typedef struct packed {
      logic [`CCRS_DIV_W-1:0] cnt;
      logic                   out;
      logic                   rise;
      logic                   run_d;
   } ccrs_div_st_t;

   typedef struct packed {
      ccrs_seq_t               seq;
      logic                    codec_rel;
      logic                    run0;
      logic                    run2;
      logic                    ext;
      logic                    bsel;
      logic [`CCRS_DIV_W-1:0]  div0;
      logic [`CCRS_DIV_W-1:0]  div2;
      logic [`CCRS_DIV_W-1:0]  gap;
      logic [`CCRS_DIV_W-1:0]  gcnt;
      logic [`CCRS_FCNT_W-1:0] fcnt;
      logic                    frame;
      logic [2:0]              xsync;
      logic [`CCRS_DATA_W-1:0] rdata;
   } ccrs_st_t;

endpackage

// file: hdl/ccrs_clk_div.sv
// ccrs_clk_div: one serial port clock divider, half period in base ticks
// assumes tick_i and run_i come from logic on mclk_i
`timescale 1ns/1ps
`include "ccrs_map.svh"

module ccrs_clk_div
   import ccrs_pkg::*;
(
   input  wire logic                   mclk_i,
   input  wire logic                   resetn_i,
   input  wire logic                   run_i,
   input  wire logic                   tick_i,
   input  wire logic [`CCRS_DIV_W-1:0] half_i,
   output logic                        clk_o,
   output logic                        rise_o
);

   ccrs_div_st_t           st_reg;
   ccrs_div_st_t           st_next;
   logic [`CCRS_DIV_W-1:0] half_eff;
   logic                   tick_eff;

   always_comb
   begin
      st_next       = st_reg;
      st_next.run_d = run_i;
      st_next.rise  = 1'b0;
      // held port runs at the processor clock over two
      half_eff = run_i ? half_i : `CCRS_DIV_RST;
      if (half_eff == '0)
         half_eff = `CCRS_DIV_RST;
      tick_eff = tick_i | ~run_i;
      if (run_i && !st_reg.run_d)
      begin
         // counter restarts on release, new rate at once
         st_next.cnt = '0;
         st_next.out = 1'b0;
      end
      else if (tick_eff)
      begin
         // >= so a divider shrunk mid-count cannot run away
         if (st_reg.cnt >= half_eff - `CCRS_DIV_W'(1))
         begin
            st_next.cnt  = '0;
            st_next.out  = ~st_reg.out;
            st_next.rise = ~st_reg.out;
         end
         else
            st_next.cnt = st_reg.cnt + `CCRS_DIV_W'(1);
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign clk_o  = st_reg.out;
   assign rise_o = st_reg.rise;

endmodule // ccrs_clk_div

// file: verification/ccrs_codec_model.sv
// ccrs_codec_model: behavioural stereo codec on the clock outputs
// assumes master, bit and frame clocks and the reset line of the sequencer
`timescale 1ns/1ps

module ccrs_codec_model (
   input  wire logic master_clk_i,
   input  wire logic bit_clk_i,
   input  wire logic frame_clk_i,
   input  wire logic resetn_line_i,
   output logic      in_reset_o = 1'b1,
   output logic      edge_sel_o = 1'b0,
   output int        slips_o = 0
);
   int   mcnt;
   int   ref_cnt;
   int   drift;
   int   nf;
   always @(negedge resetn_line_i)
   begin
      in_reset_o = 1'b1;
      nf = 0;
      drift = 0;
   end
   always @(posedge bit_clk_i)
      if (resetn_line_i && in_reset_o)
      begin
         in_reset_o = 1'b0;
         edge_sel_o = master_clk_i;
      end
   always @(posedge master_clk_i) mcnt++;
   // first frame may be partial, so the reference is the second one
   always @(posedge frame_clk_i)
   begin
      if (!in_reset_o)
      begin
         nf++;
         if (nf == 2) ref_cnt = mcnt;
         if (nf > 2) drift += mcnt - ref_cnt;
         if (drift > 10 || drift < -10)
         begin
            slips_o++;
            in_reset_o = 1'b1;
            nf = 0;
            drift = 0;
         end
      end
      mcnt = 0;
   end
endmodule // ccrs_codec_model

// file: verification/ccrs_sequencer_tb.sv
// ccrs_sequencer_tb: self-checking bench for the codec clock sequencer
// assumes ccrs_codec_model on the codec side, map header on include path
`timescale 1ns/1ps
`include "ccrs_map.svh"

module ccrs_sequencer_tb
   import ccrs_pkg::*;
;
   logic        mclk_i = 0;
   logic        resetn_i = 0;
   ccrs_bus_t   bus_i = '0;
   logic [31:0] rdata_o;
   logic        rx_pin = 0;
   logic        tx_pin = 0;
   logic        mc, bc, fc, hg, c_rst, c_edge;
   logic        mc_d, bc_d, fc_d, rel_d;
   logic        pre = 1;
   bit          sm, sb;
   logic [31:0] seed = 32'hcab7e5b9;
   int          c_slip, fail_count, samples_checked, cyc, brc, bad_def, tmo;
   int          t_h, t_m, t_b;
   int          rm[int];
   int          mq[$], bq[$], fq[$];

   always #2.5 mclk_i = ~mclk_i;

   ccrs_sequencer DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .bus_i(bus_i),
      .rdata_o(rdata_o), .port2_receive_bit_clock_in_i(rx_pin),
      .transmit_bit_clock_pin_i(tx_pin), .codec_master_clock_o(mc),
      .port2_transmit_bit_clock_out_o(bc),
      .port2_transmit_frame_sync_out_o(fc),
      .host_port_general_output_o(hg));
   ccrs_codec_model codec (.master_clk_i(mc), .bit_clk_i(bc),
      .frame_clk_i(fc), .resetn_line_i(hg), .in_reset_o(c_rst),
      .edge_sel_o(c_edge), .slips_o(c_slip));

   // external base pins: receive period 6 cycles, transmit period 8
   always @(posedge mclk_i)
   begin
      if (cyc % 3 == 0) rx_pin <= ~rx_pin;
      if (cyc % 4 == 0) tx_pin <= ~tx_pin;
   end

   always @(posedge mclk_i)
   begin
      #1;
      cyc++;
      if (pre && rel_d && (mc === mc_d || bc === bc_d || hg !== 1'b0))
         bad_def++;
      if (hg === 1'b1 && t_h < 0) t_h = cyc;
      // held clocks toggle every cycle, so a steady sample marks release;
      // the first rise after it does not depend on the held phase
      if (t_h >= 0 && mc === mc_d) sm = 1;
      if (t_h >= 0 && bc === bc_d) sb = 1;
      if (sm && mc === 1'b1 && mc_d === 1'b0 && t_m < 0) t_m = cyc;
      if (sb && bc === 1'b1 && bc_d === 1'b0 && t_b < 0) t_b = cyc;
      if (mc !== mc_d) mq.push_back(cyc);
      if (bc !== bc_d) bq.push_back(cyc);
      if (bc === 1'b1 && bc_d === 1'b0) brc++;
      if (fc !== fc_d)
      begin
         fq.push_back(brc);
         brc = 0;
      end
      mc_d = mc;
      bc_d = bc;
      fc_d = fc;
      rel_d = resetn_i;
      tmo++;
      if (tmo > 90000)
      begin
         fail_count++;
         final_report();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t read %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_int(input int got, input int exp);
      samples_checked++;
      if (got != exp)
      begin
         fail_count++;
         $display("ERROR %0t timing %0d expected %0d", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_i);
      bus_i.wr <= 1'b0;
      if (rm.exists(a)) rm[a] = d[7:0];
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask);
      logic [31:0] e;
      e = rm.exists(a) ? rm[a] : 0;
      @(posedge mclk_i);
      bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk_i);
      bus_i.rd <= 1'b0;
      #1 cmp_reg(rdata_o & mask, e & mask);
   endtask

   task automatic run_case(input bit ext, bs, input int dm, db, gap);
      int tp, hm, hb, ge;
      tp = bs ? 8 : 6;
      ge = ((gap == 0) ? 1 : gap) + db - dm;
      hm = ext ? dm * tp : dm;
      hb = ext ? 2 * tp : db;
      pre = 0;
      wr(`CCRS_OFF_CTRL, 32'h2);
      wr(`CCRS_OFF_DIV_MCLK, dm);
      wr(`CCRS_OFF_DIV_BCLK, db);
      wr(`CCRS_OFF_GAP, gap);
      t_h = -1;
      t_m = -1;
      t_b = -1;
      sm = 0;
      sb = 0;
      wr(`CCRS_OFF_CTRL, {28'h0, bs, ext, 2'b01});
      repeat (260 * hb) @(posedge mclk_i);
      mq.delete();
      bq.delete();
      fq.delete();
      repeat (300 * hb) @(posedge mclk_i);
      cmp_int(t_m > t_h + 1, 1);
      if (!ext) cmp_int(t_m - t_h, 2 + dm);
      if (!ext) cmp_int(t_b - t_m, ge);
      cmp_int(fq.size() > 2 && mq.size() > 2, 1);
      for (int i = 1; i < mq.size(); i++)
         cmp_int(mq[i] - mq[i-1], hm);
      for (int i = 1; i < bq.size(); i++)
         cmp_int(bq[i] - bq[i-1], hb);
      for (int i = 1; i < fq.size(); i++)
         cmp_int(fq[i], 32);
      cmp_int(c_slip, 0);
      cmp_reg({31'h0, c_rst}, 32'h0);
      rm[16] = 1;
      rd_chk(`CCRS_OFF_STATUS, 32'h7);
      rd_chk(`CCRS_OFF_CTRL, 32'hc);
      // a second start while running must leave the codec released
      wr(`CCRS_OFF_CTRL, {28'h0, bs, ext, 2'b01});
      repeat (4) @(posedge mclk_i);
      cmp_reg({31'h0, hg}, 32'h1);
      wr(`CCRS_OFF_CTRL, 32'h2);
      rm[16] = 6;
      rd_chk(`CCRS_OFF_STATUS, 32'h7);
      $display("test done ext %0d sel %0d div %0d %0d", ext, bs, dm, db);
   endtask

   initial
   begin
      int dm, db, g;
      rm = '{0: 0, 4: 1, 8: 1, 12: 1, 16: 6};
      repeat (12) @(posedge mclk_i);
      resetn_i <= 1'b1;
      repeat (40) @(posedge mclk_i);
      foreach (rm[a]) rd_chk(a[7:0], 32'h7);
      rd_chk(8'h14, 32'hffffffff);
      wr(8'h14, 32'h5a);
      rd_chk(8'h14, 32'hffffffff);
      cmp_int(bad_def, 0);
      $display("test done reset defaults");
      run_case(0, 0, 2, 3, 0);
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         dm = 2 << (seed % 3);
         db = 2 + seed[7:4] % 7;
         g = seed[11:8] % 5;
         if (g != 0 && g % (2 * db) == 0) g = 3;
         run_case(0, 0, dm, db, g);
      end
      run_case(1, 0, 2, 2, 1);
      run_case(1, 1, 4, 2, 1);
      final_report();
   end
endmodule // ccrs_sequencer_tb
